// file: rtl/serial_config_pkg.sv
// Constants, register map and carrier types of the serial configuration port.
// Assumes one system clock at 25 MHz and a host-driven serial clock.
package serial_config_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ        = 25_000_000;
  localparam int unsigned SOFT_RESET_MS     = 5;
  localparam int unsigned SOFT_RESET_CYCLES = SOFT_RESET_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned IDLE_US           = 10;
  localparam int unsigned IDLE_CYCLES       = IDLE_US * (SYS_CLK_HZ / 1_000_000);

  // ==========================================================================
  // Word and address layout
  localparam int unsigned WORD_W    = 8;
  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned CNT_W     = 3;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam int unsigned RW_BIT    = 7;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Register offsets
  localparam logic [14:0] ADDR_IFACE_CFG = 15'h0000;
  localparam logic [14:0] ADDR_CH_INDEX  = 15'h0008;
  localparam logic [14:0] ADDR_IN_TERM   = 15'h0016;
  localparam logic [14:0] ADDR_OUT_MODE  = 15'h0561;

  // Region bounds
  localparam logic [14:0] IFACE_LAST = 15'h000D;
  localparam logic [14:0] CONV_FIRST = 15'h0015;
  localparam logic [14:0] CONV_LAST  = 15'h027A;
  localparam logic [14:0] DEC_FIRST  = 15'h0300;
  localparam logic [14:0] DEC_LAST   = 15'h0347;
  localparam logic [14:0] OUT_FIRST  = 15'h0550;
  localparam logic [14:0] OUT_LAST   = 15'h05C5;

  // ==========================================================================
  // Reset values and fields
  localparam logic [7:0]  IFACE_CFG_RST    = 8'h00;
  localparam logic [7:0]  CH_INDEX_RST     = 8'h03;
  localparam logic [7:0]  IN_TERM_RST      = 8'h00;
  localparam logic [7:0]  OUT_MODE_RST     = 8'h01;
  localparam logic [7:0]  SOFT_RESET_CODE  = 8'h81;
  localparam logic [7:0]  IFACE_STORE_MASK = 8'h7E;
  localparam logic [7:0]  CH_INDEX_MASK    = 8'h03;
  localparam int unsigned LSB_FIRST_HI     = 6;
  localparam int unsigned LSB_FIRST_LO     = 1;
  localparam int unsigned ASCEND_HI        = 5;
  localparam int unsigned ASCEND_LO        = 2;
  localparam int unsigned CH_A_BIT         = 0;
  localparam int unsigned CH_B_BIT         = 1;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    REGION_NONE  = 3'b000,
    REGION_IFACE = 3'b001,
    REGION_CONV  = 3'b010,
    REGION_DEC   = 3'b011,
    REGION_OUT   = 3'b100
  } region_t;

  typedef enum logic [1:0] {
    PHASE_INSTR_HI = 2'b00,
    PHASE_INSTR_LO = 2'b01,
    PHASE_DATA     = 2'b10
  } phase_t;

  typedef struct packed {
    logic [7:0] out_mode;
    logic [7:0] term_a;
    logic [7:0] term_b;
    logic [1:0] ch_select;
    logic       lsb_first;
    logic       ascend;
    region_t    region;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    out_mode:  OUT_MODE_RST,
    term_a:    IN_TERM_RST,
    term_b:    IN_TERM_RST,
    ch_select: CH_INDEX_RST[1:0],
    lsb_first: 1'b0,
    ascend:    1'b0,
    region:    REGION_NONE
  };

endpackage : serial_config_pkg

// file: rtl/level_sync.sv
// Two-flop synchroniser for quasi-static levels into the system clock domain.
// Assumes the source holds each value for several destination cycles.
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;

  sync_t sync_r;
  sync_t sync_nxt;

  // ==========================================================================
  // Stages
  always_comb
  begin
    sync_nxt      = sync_r;
    sync_nxt.meta = d;
    sync_nxt.q    = sync_r.meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_r <= '{meta: RST_VAL, q: RST_VAL};
    end
    else
    begin
      sync_r <= sync_nxt;
    end
  end

  assign q = sync_r.q;

endmodule : level_sync
`default_nettype wire

// file: rtl/hold_counter.sv
// Counts cycles while run is high; done rises after LIMIT cycles.
// Dropping run clears it at once.
`timescale 1ns/1ns
`default_nettype none
module hold_counter #(
  parameter int unsigned LIMIT = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] CNT_END = W'(LIMIT - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } hold_t;

  hold_t hold_r;
  hold_t hold_nxt;

  // ==========================================================================
  // Counter
  always_comb
  begin
    hold_nxt = hold_r;
    if (!run)
    begin
      hold_nxt = '0;
    end
    else if (!hold_r.done)
    begin
      if (hold_r.cnt == CNT_END)
      begin
        hold_nxt.done = 1'b1;
      end
      else
      begin
        hold_nxt.cnt = hold_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_r <= '0;
    end
    else
    begin
      hold_r <= hold_nxt;
    end
  end

  assign done = hold_r.done;

endmodule : hold_counter
`default_nettype wire

// file: rtl/serial_config_port.sv
// Three-wire serial configuration port with its byte-wide register map.
// Assumes the host drives spi_clk idle low, changes data on falling edges
// and samples on rising edges; sys_clk runs free at 25 MHz.
//
// Notes on behaviour
// - Three pins only: serial clock, one two-way data pin, active-low select.
// - A frame starts at select falling; the next rising clock samples bit one.
// - Select held low streams words with no end.
// - Select may rise between instruction bytes; the transaction goes on when it falls; after a data byte a new instruction starts.
// - Select held high: data pin released and secondary functions enabled.
// - Instructions are 16 bits sent as two bytes, data are 8-bit words, one bit per serial clock.
// - The first instruction bit chooses read or write with MSB first; with LSB first it is the eighth bit.
// - Data pin is input while writing and drives the read byte after the instruction.
// - Most significant bit first after reset; a config bit selects LSB first.
// - Any reset loads the registers with their default values.
// - Address decoder splits the map into four regions.
// - Channel-local registers exist per channel, steered by the channel index.
// - With both channel bits set a write updates both channel copies.
// - With both channel bits set a read returns the channel A copy.
// - Global registers have one copy and ignore the channel bits.
// - Writing 0x81 to the interface register starts a 5 ms soft reset.
// - Output-mode register resets to 0x01, twos complement.
`timescale 1ns/1ns
`default_nettype none
module serial_config_port #(
  parameter int unsigned SOFT_RESET_CYCLES = serial_config_pkg::SOFT_RESET_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    spi_clk,
  input  wire logic                    port_select_n,
  input  wire logic                    sdio_in,
  output logic                         sdio_out,
  output logic                         sdio_oe,
  output logic                         secondary_en,
  output logic                         recovery_busy,
  output serial_config_pkg::cfg_t      cfg
);

  // ==========================================================================
  // State types
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic       live;
  } frame_t;

  typedef struct packed {
    serial_config_pkg::phase_t  phase;
    logic                       rw;
    logic [14:0]                addr;
    logic [6:0]                 shreg;
    logic [7:0]                 tx_byte;
    logic [7:0]                 iface_cfg;
    logic [7:0]                 ch_index;
    logic [7:0]                 term_a;
    logic [7:0]                 term_b;
    logic [7:0]                 out_mode;
    serial_config_pkg::region_t region;
    logic                       soft_req;
  } link_t;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
  } drive_t;

  typedef struct packed {
    logic                    link_rst;
    logic                    busy;
    serial_config_pkg::cfg_t cfg;
  } sys_t;

  localparam link_t LINK_RST = '{
    phase:     serial_config_pkg::PHASE_INSTR_HI,
    rw:        1'b0,
    addr:      '0,
    shreg:     '0,
    tx_byte:   serial_config_pkg::ZERO_BYTE,
    iface_cfg: serial_config_pkg::IFACE_CFG_RST,
    ch_index:  serial_config_pkg::CH_INDEX_RST,
    term_a:    serial_config_pkg::IN_TERM_RST,
    term_b:    serial_config_pkg::IN_TERM_RST,
    out_mode:  serial_config_pkg::OUT_MODE_RST,
    region:    serial_config_pkg::REGION_NONE,
    soft_req:  1'b0
  };

  frame_t frame_r;
  frame_t frame_nxt;
  link_t  link_r;
  link_t  link_nxt;
  drive_t drive_r;
  drive_t drive_nxt;
  sys_t   sys_r;
  sys_t   sys_nxt;

  logic                    frame_clr;
  logic                    lsb_first;
  logic                    ascend;
  logic [7:0]              raw_byte;
  logic [7:0]              rx_byte;
  logic [14:0]             cur_addr;
  logic [14:0]             next_addr;
  serial_config_pkg::phase_t cur_phase;
  serial_config_pkg::cfg_t cfg_link;
  serial_config_pkg::cfg_t cfg_s;
  logic                    soft_req_s;
  logic                    select_s;
  logic                    idle_long;
  logic                    soft_done;

  // ==========================================================================
  // Functions
  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : bit_rev

  function automatic logic tx_bit(input logic [7:0] b, input logic [2:0] cnt, input logic lsb);
    logic [2:0] idx;
    idx = lsb ? cnt : (serial_config_pkg::BIT_LAST - cnt);
    return b[idx];
  endfunction : tx_bit

  function automatic serial_config_pkg::region_t region_of(input logic [14:0] a);
    serial_config_pkg::region_t r;
    r = serial_config_pkg::REGION_NONE;
    if (a <= serial_config_pkg::IFACE_LAST)
    begin
      r = serial_config_pkg::REGION_IFACE;
    end
    else if (a >= serial_config_pkg::CONV_FIRST && a <= serial_config_pkg::CONV_LAST)
    begin
      r = serial_config_pkg::REGION_CONV;
    end
    else if (a >= serial_config_pkg::DEC_FIRST && a <= serial_config_pkg::DEC_LAST)
    begin
      r = serial_config_pkg::REGION_DEC;
    end
    else if (a >= serial_config_pkg::OUT_FIRST && a <= serial_config_pkg::OUT_LAST)
    begin
      r = serial_config_pkg::REGION_OUT;
    end
    return r;
  endfunction : region_of

  function automatic logic [7:0] read_reg(input link_t s, input logic [14:0] a);
    logic [7:0] v;
    v = serial_config_pkg::ZERO_BYTE;
    if (region_of(a) != serial_config_pkg::REGION_NONE)
    begin
      case (a)
        serial_config_pkg::ADDR_IFACE_CFG: v = s.iface_cfg;
        serial_config_pkg::ADDR_CH_INDEX:  v = s.ch_index;
        serial_config_pkg::ADDR_IN_TERM:
        begin
          if (s.ch_index[serial_config_pkg::CH_A_BIT])
          begin
            v = s.term_a;
          end
          else if (s.ch_index[serial_config_pkg::CH_B_BIT])
          begin
            v = s.term_b;
          end
        end
        serial_config_pkg::ADDR_OUT_MODE:  v = s.out_mode;
        default:                           v = serial_config_pkg::ZERO_BYTE;
      endcase
    end
    return v;
  endfunction : read_reg

  // ==========================================================================
  // Link side: bit counter, cleared while select is high
  // A partial byte dies with the counter when select rises.
  assign frame_clr = port_select_n | sys_r.link_rst;

  always_comb
  begin
    frame_nxt         = frame_r;
    frame_nxt.live    = 1'b1;
    frame_nxt.bit_cnt = 3'(frame_r.bit_cnt + 1'b1);
  end

  always_ff @(posedge spi_clk or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      frame_r <= '0;
    end
    else
    begin
      frame_r <= frame_nxt;
    end
  end

  // ==========================================================================
  // Link side: instruction, address and register file
  assign lsb_first = link_r.iface_cfg[serial_config_pkg::LSB_FIRST_HI]
                   | link_r.iface_cfg[serial_config_pkg::LSB_FIRST_LO];
  assign ascend    = link_r.iface_cfg[serial_config_pkg::ASCEND_HI]
                   | link_r.iface_cfg[serial_config_pkg::ASCEND_LO];
  assign raw_byte  = {link_r.shreg, sdio_in};
  assign rx_byte   = lsb_first ? bit_rev(raw_byte) : raw_byte;
  assign cur_addr  = {link_r.addr[14:8], rx_byte};
  assign next_addr = ascend ? 15'(link_r.addr + 1'b1) : 15'(link_r.addr - 1'b1);

  // A stall before the data phase resumes; after data it starts a new instruction.
  assign cur_phase = (!frame_r.live && link_r.phase == serial_config_pkg::PHASE_DATA)
                   ? serial_config_pkg::PHASE_INSTR_HI : link_r.phase;

  always_comb
  begin
    link_nxt       = link_r;
    link_nxt.phase = cur_phase;
    link_nxt.shreg = raw_byte[6:0];
    if (frame_r.bit_cnt == serial_config_pkg::BIT_LAST)
    begin
      case (cur_phase)
        serial_config_pkg::PHASE_INSTR_HI:
        begin
          link_nxt.rw         = rx_byte[serial_config_pkg::RW_BIT];
          link_nxt.addr[14:8] = rx_byte[6:0];
          link_nxt.phase      = serial_config_pkg::PHASE_INSTR_LO;
        end
        serial_config_pkg::PHASE_INSTR_LO:
        begin
          link_nxt.addr    = cur_addr;
          link_nxt.region  = region_of(cur_addr);
          link_nxt.phase   = serial_config_pkg::PHASE_DATA;
          link_nxt.tx_byte = read_reg(link_r, cur_addr);
        end
        serial_config_pkg::PHASE_DATA:
        begin
          if (!link_r.rw)
          begin
            case (link_r.addr)
              serial_config_pkg::ADDR_IFACE_CFG:
              begin
                if (rx_byte == serial_config_pkg::SOFT_RESET_CODE)
                begin
                  link_nxt.soft_req = 1'b1;
                end
                link_nxt.iface_cfg = rx_byte & serial_config_pkg::IFACE_STORE_MASK;
              end
              serial_config_pkg::ADDR_CH_INDEX:
              begin
                link_nxt.ch_index = rx_byte & serial_config_pkg::CH_INDEX_MASK;
              end
              serial_config_pkg::ADDR_IN_TERM:
              begin
                if (link_r.ch_index[serial_config_pkg::CH_A_BIT])
                begin
                  link_nxt.term_a = rx_byte;
                end
                if (link_r.ch_index[serial_config_pkg::CH_B_BIT])
                begin
                  link_nxt.term_b = rx_byte;
                end
              end
              serial_config_pkg::ADDR_OUT_MODE:
              begin
                link_nxt.out_mode = rx_byte;
              end
              default:
              begin
                link_nxt.out_mode = link_r.out_mode;
              end
            endcase
          end
          // Streaming moves on to the neighbouring address
          link_nxt.addr    = next_addr;
          link_nxt.region  = region_of(next_addr);
          link_nxt.tx_byte = read_reg(link_r, next_addr);
        end
        default:
        begin
          link_nxt.phase = serial_config_pkg::PHASE_INSTR_HI;
        end
      endcase
    end
  end

  // The reset bridge releases with spi_clk stopped, so no recovery hazard.
  always_ff @(posedge spi_clk or posedge sys_r.link_rst)
  begin
    if (sys_r.link_rst)
    begin
      link_r <= LINK_RST;
    end
    else
    begin
      link_r <= link_nxt;
    end
  end

  // ==========================================================================
  // Link side: data pin driver, updated on falling edges
  always_comb
  begin
    drive_nxt         = drive_r;
    drive_nxt.sdio_oe = frame_r.live && link_r.rw
                      && link_r.phase == serial_config_pkg::PHASE_DATA;
    drive_nxt.sdio_out = drive_nxt.sdio_oe && tx_bit(link_r.tx_byte, frame_r.bit_cnt, lsb_first);
  end

  // Select high releases the pin at once.
  always_ff @(negedge spi_clk or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      drive_r <= '0;
    end
    else
    begin
      drive_r <= drive_nxt;
    end
  end

  assign sdio_out = drive_r.sdio_out;
  assign sdio_oe  = drive_r.sdio_oe;

  // ==========================================================================
  // Crossings into the system domain
  // Configuration is synchronised, then taken only once select high says the link is quiet.
  always_comb
  begin
    cfg_link           = serial_config_pkg::CFG_RST;
    cfg_link.out_mode  = link_r.out_mode;
    cfg_link.term_a    = link_r.term_a;
    cfg_link.term_b    = link_r.term_b;
    cfg_link.ch_select = link_r.ch_index[1:0];
    cfg_link.lsb_first = lsb_first;
    cfg_link.ascend    = ascend;
    cfg_link.region    = link_r.region;
  end

  level_sync #(
    .W       ($bits(serial_config_pkg::cfg_t)),
    .RST_VAL (serial_config_pkg::CFG_RST)
  ) u_cfg_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (cfg_link),
    .q   (cfg_s)
  );

  level_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_soft_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (link_r.soft_req),
    .q   (soft_req_s)
  );

  level_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_select_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (port_select_n),
    .q   (select_s)
  );

  // ==========================================================================
  // System side: soft reset recovery and idle detection
  hold_counter #(
    .LIMIT (SOFT_RESET_CYCLES)
  ) u_soft_timer (
    .clk  (sys_clk),
    .rst  (rst),
    .run  (sys_r.busy),
    .done (soft_done)
  );

  // A short idle time keeps glitches on select from flipping pin functions.
  hold_counter #(
    .LIMIT (serial_config_pkg::IDLE_CYCLES)
  ) u_idle_timer (
    .clk  (sys_clk),
    .rst  (rst),
    .run  (select_s),
    .done (idle_long)
  );

  always_comb
  begin
    sys_nxt = sys_r;
    // A half-changed word never reaches cfg: link state moves only while select is low or in a soft reset, when busy holds cfg at defaults
    if (sys_r.busy)
    begin
      sys_nxt.cfg = serial_config_pkg::CFG_RST;
    end
    else if (select_s)
    begin
      sys_nxt.cfg = cfg_s;
    end
    if (sys_r.busy)
    begin
      if (soft_done)
      begin
        sys_nxt.busy     = 1'b0;
        sys_nxt.link_rst = 1'b0;
      end
    end
    else if (soft_req_s)
    begin
      sys_nxt.busy     = 1'b1;
      sys_nxt.link_rst = 1'b1;
    end
    else
    begin
      sys_nxt.link_rst = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sys_r <= '{link_rst: 1'b1, busy: 1'b0, cfg: serial_config_pkg::CFG_RST};
    end
    else
    begin
      sys_r <= sys_nxt;
    end
  end

  assign recovery_busy = sys_r.busy;
  assign cfg           = sys_r.cfg;
  assign secondary_en  = idle_long;

endmodule : serial_config_port
`default_nettype wire

// file: dv/serial_config_port_asserts.sv
// Concurrent checks on the serial configuration port, bound to its ports.
// Assumes the bound instance hands on its SOFT_RESET_CYCLES value.
`timescale 1ns/1ns
`default_nettype none
module serial_config_port_asserts #(
  parameter int unsigned SOFT_RESET_CYCLES = 20
) (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic                    spi_clk,
  input wire logic                    port_select_n,
  input wire logic                    sdio_in,
  input wire logic                    sdio_out,
  input wire logic                    sdio_oe,
  input wire logic                    secondary_en,
  input wire logic                    recovery_busy,
  input wire serial_config_pkg::cfg_t cfg
);
  // ==========
  // Run lengths; wide so they never wrap within a run
  logic [31:0] busy_r;
  logic [31:0] busy_nxt;
  logic [31:0] high_r;
  logic [31:0] high_nxt;
  always_comb
  begin
    busy_nxt = recovery_busy ? busy_r + 32'h1 : 32'h0;
    high_nxt = port_select_n ? high_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk)
  begin
    busy_r <= rst ? 32'h0 : busy_nxt;
    high_r <= rst ? 32'h0 : high_nxt;
  end
  // ==========
  // Properties
  rst_defaults_a: assert property (@(posedge sys_clk) rst [*2] |-> cfg == serial_config_pkg::CFG_RST)
    else $error("cfg not at defaults in reset");
  recover_dflt_a: assert property (@(posedge sys_clk) disable iff (rst)
    recovery_busy [*4] |-> cfg == serial_config_pkg::CFG_RST) else $error("cfg not reset in recovery");
  busy_long_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(recovery_busy) |-> busy_r >= SOFT_RESET_CYCLES) else $error("recovery too short");
  busy_short_a: assert property (@(posedge sys_clk) disable iff (rst)
    recovery_busy |-> busy_r <= SOFT_RESET_CYCLES + 4) else $error("recovery too long");
  pin_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    port_select_n |-> !sdio_oe) else $error("pin driven while deselected");
  sec_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    !port_select_n [*4] |-> !secondary_en) else $error("secondary still on");
  sec_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(secondary_en) |-> high_r >= serial_config_pkg::IDLE_CYCLES) else $error("secondary too early");
  cfg_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    (port_select_n && !recovery_busy) [*5] |-> $stable(cfg)) else $error("cfg moved while idle");
endmodule : serial_config_port_asserts
bind serial_config_port serial_config_port_asserts #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (
  .sys_clk, .rst, .spi_clk, .port_select_n, .sdio_in, .sdio_out, .sdio_oe, .secondary_en, .recovery_busy, .cfg
);
`default_nettype wire

// file: dv/spi_host_model.sv
// Host serial master model: mode 0, clock idle low, 125 ns period in frames.
// Assumes the bench resolves the data wire and returns it on sdio_w.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic      spi_clk,
  output logic      port_select_n,
  output logic      sdio_d,
  input  wire logic sdio_w
);
  // ==========
  // Idle: clock stands still outside frames
  initial
  begin
    spi_clk = 1'b0;
    port_select_n = 1'b1;
    sdio_d = 1'b0;
  end
  // ==========
  // n bits of a byte; while reading the pin toggles so stale data never passes
  task automatic shift(input logic [7:0] tx, input bit lsb, input bit rd, input int n, output logic [7:0] rx);
    int k;
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      k = lsb ? i : 7 - i;
      sdio_d = rd ? ~sdio_d : tx[k];
      #62;
      spi_clk = 1'b1;
      rx[k] = sdio_w;
      #63;
      spi_clk = 1'b0;
    end
  endtask : shift
  // ==========
  // Two instruction bytes, nd data bytes; st stalls select high after byte one
  task automatic frame(input bit rd, input logic [14:0] a, input logic [7:0] d, input bit lsb, input int n,
                       input int nd, input bit st, output logic [15:0] q);
    logic [7:0] r;
    q = 16'h0000;
    port_select_n = 1'b0;
    shift({rd, a[14:8]}, lsb, 1'b0, 8, r);
    if (st)
    begin
      #62 port_select_n = 1'b1;
      #500 port_select_n = 1'b0;
    end
    shift(a[7:0], lsb, 1'b0, 8, r);
    for (int j = 0; j < nd; j++)
    begin
      shift(d, lsb, rd, n, r);
      q = {q[7:0], r};
    end
    #62 port_select_n = 1'b1;
    #500;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// file: dv/tb_serial_config_port.sv
// Self-checking bench for the serial configuration port with a host model.
// Assumes a shortened soft-reset count; cfg is read once its sync settled.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_config_port;
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  wire logic               spi_clk;
  wire logic               port_select_n;
  wire logic               sdio_d;
  wire logic               sdio_w;
  logic                    sdio_out;
  logic                    sdio_oe;
  logic                    secondary_en;
  logic                    recovery_busy;
  serial_config_pkg::cfg_t cfg;
  int                      fails = 0;
  int                      n_compared = 0;
  // ==========
  // Clock, wire resolution and instances
  always #20 sys_clk = ~sys_clk;
  assign sdio_w = sdio_oe ? sdio_out : sdio_d;
  spi_host_model u_host (.spi_clk, .port_select_n, .sdio_d, .sdio_w);
  serial_config_port #(.SOFT_RESET_CYCLES(20)) u_dut (.sys_clk, .rst, .spi_clk, .port_select_n,
    .sdio_in(sdio_w), .sdio_out, .sdio_oe, .secondary_en, .recovery_busy, .cfg);
  // ==========
  // Shared tasks
  task automatic summarize();
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic acc(input bit rd, input logic [14:0] a, input logic [7:0] d, input bit lsb, output logic [7:0] q);
    logic [15:0] w;
    u_host.frame(rd, a, d, lsb, 8, 1, 1'b0, w);
    q = w[7:0];
  endtask : acc
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b1, a, 8'h00, 1'b0, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, a, d, 1'b0, q);
  endtask : wr
  // ==========
  // Scenarios
  task automatic t_defaults();
    logic [14:0] am [5] = '{15'h00D, 15'h013, 15'h27A, 15'h347, 15'h5C5};
    logic [2:0]  rg [5] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4};
    chk(cfg, serial_config_pkg::CFG_RST);
    chk({secondary_en, sdio_oe}, 2'b10);
    rd_chk(15'h561, 8'h01);
    rd_chk(15'h008, 8'h03);
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(am[i], 8'h00);
      chk(cfg.region, rg[i]);
    end
  endtask : t_defaults
  task automatic t_frames();
    logic [15:0] q;
    u_host.frame(1'b1, 15'h009, 8'h00, 1'b0, 8, 2, 1'b0, q);
    chk(q, 16'h0003);
    u_host.frame(1'b0, 15'h561, 8'hA5, 1'b0, 4, 1, 1'b0, q);
    chk(cfg.out_mode, 8'h01);
    u_host.frame(1'b0, 15'h561, 8'h3C, 1'b0, 8, 1, 1'b1, q);
    chk(cfg.out_mode, 8'h3C);
    wr(15'h000, 8'h24);
    u_host.frame(1'b1, 15'h007, 8'h00, 1'b0, 8, 2, 1'b0, q);
    chk({cfg.ascend, q}, 17'h10003);
    wr(15'h000, 8'h00);
  endtask : t_frames
  task automatic t_channel();
    wr(15'h008, 8'h01);
    wr(15'h016, 8'h5A);
    chk({cfg.ch_select, cfg.term_a, cfg.term_b}, 18'h15A00);
    wr(15'h008, 8'h02);
    wr(15'h016, 8'h3C);
    chk({cfg.term_a, cfg.term_b}, 16'h5A3C);
    wr(15'h008, 8'h03);
    wr(15'h016, 8'h77);
    chk({cfg.term_a, cfg.term_b}, 16'h7777);
    wr(15'h008, 8'h02);
    wr(15'h016, 8'h11);
    wr(15'h008, 8'h03);
    rd_chk(15'h016, 8'h77);
    wr(15'h008, 8'h00);
    wr(15'h561, 8'h01);
    chk(cfg.out_mode, 8'h01);
  endtask : t_channel
  task automatic t_lsb_reset();
    logic [7:0] q;
    int         i;
    wr(15'h000, 8'h42);
    chk(cfg.lsb_first, 1'b1);
    acc(1'b0, 15'h561, 8'hC4, 1'b1, q);
    chk(cfg.out_mode, 8'hC4);
    acc(1'b0, 15'h000, 8'h81, 1'b1, q);
    chk(recovery_busy, 1'b1);
    for (i = 0; i < 100 && recovery_busy !== 1'b0; i++)
      @(posedge sys_clk);
    if (i == 100)
    begin
      fails++;
      summarize();
    end
    #2;
    chk(cfg, serial_config_pkg::CFG_RST);
    rd_chk(15'h000, 8'h00);
  endtask : t_lsb_reset
  // ==========
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    #2 rst = 1'b0;
    repeat (300) @(posedge sys_clk);
    #2;
    t_defaults();
    t_frames();
    t_channel();
    t_lsb_reset();
    summarize();
  end
endmodule : tb_serial_config_port
`default_nettype wire
